/* File: hw/sensor_aux_config_regs.sv */
/*
 * Auxiliary configuration register bank of an image sensor: serial output
 * bias, charge pumps, temperature diode, serializer power and black level
 * calibration settings, reached over a four wire serial configuration port.
 * Assumes the serial clock runs at most at an eighth of i_sys_clk and that
 * the temperature code changes slowly against i_sys_clk.
 */
`timescale 1ns/10ps
`include "sensor_aux_config_params.svh"

module sensor_aux_config_regs (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Serial configuration port
    input wire logic i_spi_sck,
    input wire logic i_spi_ss_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    // Temperature diode converter
    input wire logic [7:0] i_temp_code,
    output logic o_temp_diode_en,
    // Analog controls
    output logic [7:0] o_serial_bias,
    output sensor_aux_config_pkg::pump_ctrl_t o_pump,
    output sensor_aux_config_pkg::ser_pwr_t o_ser_pwr,
    output sensor_aux_config_pkg::black_cal_t o_black_cal
);

    typedef struct packed {
        sensor_aux_config_pkg::phase_t phase;
        logic [4:0] bit_cnt;
        logic [23:0] shift_in;
        logic [15:0] shift_out;
        logic [8:0] addr;
        logic write;
        logic sck_q;
        logic miso;
        logic [7:0] temp_prev;
        logic [7:0] sample_count;
        sensor_aux_config_pkg::regs_t regs;
    } state_t;

    state_t st;
    state_t next_st;
    sensor_aux_config_pkg::spi_pins_t pins;
    logic [7:0] temp_s;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    pin_sync #(
        .WIDTH(11)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_async({i_spi_sck, i_spi_ss_n, i_spi_mosi, i_temp_code}),
        .o_sync({pins.sck, pins.ss_n, pins.mosi, temp_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode

    function automatic logic [15:0] read_word(
        input sensor_aux_config_pkg::regs_t r,
        input logic [8:0] a
    );
        logic [15:0] d;
        d = 16'h0000;
        unique case (a)
            `ADDR_SERIAL_OUTPUT_BIAS: d = {8'h00, r.serial_bias};
            `ADDR_RESERVED_BIAS_WORD: d = r.rsvd_bias;
            `ADDR_PIXEL_PUMP_CONFIG: d = r.pump_cfg & `PUMP_CFG_MASK;
            `ADDR_RESERVED_WORD_A: d = {6'h00, r.rsvd_a};
            `ADDR_RESERVED_WORD_B: d = r.rsvd_b;
            `ADDR_THERMAL_DIODE_ENABLE: d = {15'h0000, r.temp_en};
            `ADDR_THERMAL_READOUT: d = {8'h00, r.temp_code};
            `ADDR_SERIALIZER_POWER_CONTROL: d = {13'h0000, r.ser_pwr};
            `ADDR_BLACK_LEVEL_CALIBRATION: d = r.black_cal;
            default: d = 16'h0000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode

    function automatic sensor_aux_config_pkg::regs_t write_word(
        input sensor_aux_config_pkg::regs_t r,
        input logic [8:0] a,
        input logic [15:0] d
    );
        sensor_aux_config_pkg::regs_t n;
        n = r;
        unique case (a)
            `ADDR_SERIAL_OUTPUT_BIAS: n.serial_bias = d[7:0];
            `ADDR_RESERVED_BIAS_WORD: n.rsvd_bias = d;
            `ADDR_PIXEL_PUMP_CONFIG: n.pump_cfg = d & `PUMP_CFG_MASK;
            `ADDR_RESERVED_WORD_A: n.rsvd_a = d[9:0];
            `ADDR_RESERVED_WORD_B: n.rsvd_b = d;
            `ADDR_THERMAL_DIODE_ENABLE: n.temp_en = d[0];
            `ADDR_SERIALIZER_POWER_CONTROL: n.ser_pwr = d[2:0];
            `ADDR_BLACK_LEVEL_CALIBRATION: n.black_cal = d;
            default: n = r;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic sck_rise;
        logic sck_fall;
        logic [2:0] exp_v;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        exp_v = 3'h0;
        next_st = st;
        sck_rise = pins.sck & ~st.sck_q;
        sck_fall = ~pins.sck & st.sck_q;
        next_st.sck_q = pins.sck;

        // Serial frame: address, direction, data, all MSB first
        if (pins.ss_n) begin
            next_st.phase = sensor_aux_config_pkg::PH_IDLE;
            next_st.bit_cnt = 5'h00;
            next_st.miso = 1'b0;
        end else if (sck_rise) begin
            next_st.shift_in = {st.shift_in[22:0], pins.mosi};
            next_st.bit_cnt = st.bit_cnt + 5'h01;
            unique case (st.phase)
                sensor_aux_config_pkg::PH_IDLE,
                sensor_aux_config_pkg::PH_ADDR: begin
                    next_st.phase = sensor_aux_config_pkg::PH_ADDR;
                    if (st.bit_cnt == `FRAME_DIR_LAST) begin
                        next_st.addr = st.shift_in[8:0];
                        next_st.write = pins.mosi;
                        next_st.shift_out = read_word(st.regs, st.shift_in[8:0]);
                        next_st.phase = sensor_aux_config_pkg::PH_DATA;
                    end
                end
                sensor_aux_config_pkg::PH_DATA: begin
                    if (st.bit_cnt == `FRAME_DATA_LAST) begin
                        next_st.phase = sensor_aux_config_pkg::PH_DONE;
                        if (st.write) begin
                            next_st.regs = write_word(st.regs, st.addr,
                                {st.shift_in[14:0], pins.mosi});
                        end
                    end
                end
                sensor_aux_config_pkg::PH_DONE: begin
                    next_st.bit_cnt = st.bit_cnt;
                end
            endcase
        end else if (sck_fall && st.phase == sensor_aux_config_pkg::PH_DATA) begin
            next_st.miso = st.shift_out[15];
            next_st.shift_out = {st.shift_out[14:0], 1'b0};
        end

        // Temperature captured when two samples agree, cleared when off
        next_st.temp_prev = temp_s;
        if (!next_st.regs.temp_en) begin
            next_st.regs.temp_code = `RST_THERMAL_READOUT;
        end else if (temp_s == st.temp_prev) begin
            next_st.regs.temp_code = temp_s;
        end

        // Sample count is two to the exponent
        exp_v = next_st.regs.black_cal[`BLACK_EXP_LSB +: `BLACK_EXP_BITS];
        next_st.sample_count = 8'h01 << exp_v;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.phase <= sensor_aux_config_pkg::PH_IDLE;
            st.sck_q <= 1'b0;
            st.sample_count <= 8'h01;
            st.regs.serial_bias <= `RST_SERIAL_OUTPUT_BIAS;
            st.regs.rsvd_bias <= `RST_RESERVED_BIAS_WORD;
            st.regs.pump_cfg <= `RST_PIXEL_PUMP_CONFIG;
            st.regs.rsvd_a <= `RST_RESERVED_WORD_A;
            st.regs.rsvd_b <= `RST_RESERVED_WORD_B;
            st.regs.temp_en <= `RST_THERMAL_DIODE_ENABLE;
            st.regs.temp_code <= `RST_THERMAL_READOUT;
            st.regs.ser_pwr <= `RST_SERIALIZER_POWER_CONTROL;
            st.regs.black_cal <= `RST_BLACK_LEVEL_CALIBRATION;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state flip-flops

    assign o_spi_miso = st.miso;
    assign o_temp_diode_en = st.regs.temp_en;
    assign o_serial_bias = st.regs.serial_bias;
    assign o_pump.pd_en = st.regs.pump_cfg[`PUMP_PD_EN_BIT];
    assign o_pump.fd_en = st.regs.pump_cfg[`PUMP_FD_EN_BIT];
    assign o_pump.pd_trim = st.regs.pump_cfg[`PUMP_PD_TRIM_LSB +: `PUMP_TRIM_BITS];
    assign o_pump.fd_trim = st.regs.pump_cfg[`PUMP_FD_TRIM_LSB +: `PUMP_TRIM_BITS];
    assign o_ser_pwr.clk_out_up = st.regs.ser_pwr[`SER_CLK_BIT];
    assign o_ser_pwr.sync_up = st.regs.ser_pwr[`SER_SYNC_BIT];
    assign o_ser_pwr.data_up = st.regs.ser_pwr[`SER_DATA_BIT];
    assign o_black_cal.target = st.regs.black_cal[`BLACK_TARGET_LSB +: `BLACK_TARGET_BITS];
    assign o_black_cal.samples_exp = st.regs.black_cal[`BLACK_EXP_LSB +: `BLACK_EXP_BITS];
    assign o_black_cal.sample_count = st.sample_count;

endmodule

/* File: inc/sensor_aux_config_params.svh */
/*
 * Register offsets, reset values, field positions and serial frame sizes
 * for the auxiliary sensor configuration bank.
 * Assumes nothing beyond inclusion by bare name.
 */
`ifndef SENSOR_AUX_CONFIG_PARAMS_SVH
`define SENSOR_AUX_CONFIG_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Word addresses on the serial configuration port
`define ADDR_SERIAL_OUTPUT_BIAS 9'h044
`define ADDR_RESERVED_BIAS_WORD 9'h046
`define ADDR_PIXEL_PUMP_CONFIG 9'h048
`define ADDR_RESERVED_WORD_A 9'h050
`define ADDR_RESERVED_WORD_B 9'h051
`define ADDR_THERMAL_DIODE_ENABLE 9'h060
`define ADDR_THERMAL_READOUT 9'h061
`define ADDR_SERIALIZER_POWER_CONTROL 9'h070
`define ADDR_BLACK_LEVEL_CALIBRATION 9'h080

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_SERIAL_OUTPUT_BIAS 8'h88
`define RST_RESERVED_BIAS_WORD 16'h8888
`define RST_PIXEL_PUMP_CONFIG 16'h1200
`define RST_RESERVED_WORD_A 10'h000
`define RST_RESERVED_WORD_B 16'h8881
`define RST_THERMAL_DIODE_ENABLE 1'h0
`define RST_THERMAL_READOUT 8'h00
`define RST_SERIALIZER_POWER_CONTROL 3'h0
`define RST_BLACK_LEVEL_CALIBRATION 16'h4008

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define PUMP_PD_EN_BIT 0
`define PUMP_FD_EN_BIT 1
`define PUMP_PD_TRIM_LSB 8
`define PUMP_FD_TRIM_LSB 12
`define PUMP_TRIM_BITS 3
`define PUMP_CFG_MASK 16'h7703
`define SER_CLK_BIT 0
`define SER_SYNC_BIT 1
`define SER_DATA_BIT 2
`define BLACK_TARGET_LSB 0
`define BLACK_TARGET_BITS 8
`define BLACK_EXP_LSB 8
`define BLACK_EXP_BITS 3

////////////////////////////////////////////////////////////////////////////////
// Serial frame: address, direction bit, data word
`define FRAME_ADDR_BITS 9
`define FRAME_DATA_BITS 16
`define FRAME_DIR_LAST 5'd9
`define FRAME_DATA_LAST 5'd25

`endif

/* File: inc/sensor_aux_config_pkg.sv */
/*
 * Types shared by the auxiliary sensor configuration bank.
 * Assumes the params header is compiled alongside.
 */
package sensor_aux_config_pkg;

    // Serial frame phase, Gray along idle, address, data, done
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ADDR = 2'h1,
        PH_DATA = 2'h3,
        PH_DONE = 2'h2
    } phase_t;

    // Stored register contents
    typedef struct packed {
        logic [7:0] serial_bias;
        logic [15:0] rsvd_bias;
        logic [15:0] pump_cfg;
        logic [9:0] rsvd_a;
        logic [15:0] rsvd_b;
        logic temp_en;
        logic [7:0] temp_code;
        logic [2:0] ser_pwr;
        logic [15:0] black_cal;
    } regs_t;

    // Serial port pins after synchronisation
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
    } spi_pins_t;

    // Charge pump controls
    typedef struct packed {
        logic pd_en;
        logic fd_en;
        logic [2:0] pd_trim;
        logic [2:0] fd_trim;
    } pump_ctrl_t;

    // Serializer power-up controls
    typedef struct packed {
        logic clk_out_up;
        logic sync_up;
        logic data_up;
    } ser_pwr_t;

    // Black calibration settings
    typedef struct packed {
        logic [7:0] target;
        logic [2:0] samples_exp;
        logic [7:0] sample_count;
    } black_cal_t;

endpackage

/* File: hw/pin_sync.sv */
/*
 * Two flip-flop synchroniser for a group of asynchronous inputs.
 * Assumes each input is a level that stays stable for several clocks.
 */
`timescale 1ns/10ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // Meta stage feeds only the stable stage
    always_comb begin
        next_st = st;
        next_st.meta = i_async;
        next_st.stable = st.meta;
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;

endmodule

/* File: test/sensor_aux_config_properties.sv */
/* Port checker for the auxiliary configuration bank.
   Bound to the design from the testbench top file. */
`timescale 1ns/10ps
module sensor_aux_config_properties (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Watched ports
    input wire logic i_spi_ss_n,
    input wire logic o_temp_diode_en,
    input wire sensor_aux_config_pkg::pump_ctrl_t o_pump,
    input wire sensor_aux_config_pkg::ser_pwr_t o_ser_pwr,
    input wire sensor_aux_config_pkg::black_cal_t o_black_cal
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////
    // Reset values at release
    pump_reset_a: assert property ($rose(i_arst_n) |-> o_pump == 8'h11)
        else $error("pump controls not at reset value");
    ser_reset_a: assert property ($rose(i_arst_n) |-> o_ser_pwr == 3'h0)
        else $error("serializer power not at reset value");
    black_reset_a: assert property ($rose(i_arst_n) |->
        o_black_cal.target == 8'h08 && o_black_cal.samples_exp == 3'h0)
        else $error("black calibration not at reset value");
    // Sample count follows exponent
    count_pow_a: assert property ($stable(o_black_cal.samples_exp) |->
        o_black_cal.sample_count == 8'(8'h01 << o_black_cal.samples_exp))
        else $error("sample count not two to exponent");
    // Controls hold outside frames
    pump_hold_a: assert property (i_spi_ss_n [*8] |-> $stable(o_pump))
        else $error("pump controls moved outside a frame");
    ser_hold_a: assert property (i_spi_ss_n [*8] |-> $stable(o_ser_pwr))
        else $error("serializer power moved outside a frame");
    black_hold_a: assert property (i_spi_ss_n [*8] |-> $stable(o_black_cal))
        else $error("black calibration moved outside a frame");
    temp_hold_a: assert property (i_spi_ss_n [*8] |-> $stable(o_temp_diode_en))
        else $error("diode enable moved outside a frame");
endmodule

/* File: test/testbench.sv */
/* Self-checking bench for the auxiliary configuration bank.
   Drives the serial port at the falling clock edge. */
`timescale 1ns/10ps
module testbench;
    logic sys_clk;
    logic arst_n;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    logic [7:0] temp_code;
    logic temp_en;
    logic [7:0] serial_bias;
    sensor_aux_config_pkg::pump_ctrl_t pump;
    sensor_aux_config_pkg::ser_pwr_t ser_pwr;
    sensor_aux_config_pkg::black_cal_t black_cal;
    int err_total = 0;
    int tests_run = 0;
    int seed = 60;
    logic [8:0] adr[11] = '{9'h044, 9'h046, 9'h048, 9'h050, 9'h051, 9'h060, 9'h061,
        9'h070, 9'h080, 9'h045, 9'h1ff};
    logic [15:0] rstv[11] = '{16'h0088, 16'h8888, 16'h1200, 16'h0000, 16'h8881, 16'h0000,
        16'h0000, 16'h0000, 16'h4008, 16'h0000, 16'h0000};
    logic [15:0] msk[11] = '{16'h00ff, 16'hffff, 16'h7703, 16'h03ff, 16'hffff, 16'h0001,
        16'h0000, 16'h0007, 16'hffff, 16'h0000, 16'h0000};
    logic [15:0] mdl[11];

    sensor_aux_config_regs DUT (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_spi_sck(sck),
        .i_spi_ss_n(ss_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .i_temp_code(temp_code),
        .o_temp_diode_en(temp_en), .o_serial_bias(serial_bias), .o_pump(pump),
        .o_ser_pwr(ser_pwr), .o_black_cal(black_cal));

    ////////////////////////////////////////
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Count line, verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compare one value and count mismatches
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One serial frame, cut short when nbits is below 26
    task automatic frame(logic [8:0] a, logic wr, logic [15:0] d, int nbits,
        output logic [15:0] q);
        logic [25:0] f;
        f = {a, wr, d};
        ss_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 25; i >= 26 - nbits; i--) begin
            mosi = f[i];
            repeat (5) @(negedge sys_clk);
            q = {q[14:0], miso};
            sck = 1'b1;
            repeat (5) @(negedge sys_clk);
            sck = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        ss_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask

    // Port values against the model
    task automatic outs();
        logic [15:0] p;
        p = mdl[2];
        check("pump", 16'(pump), {8'h00, p[0], p[1], p[10:8], p[14:12]});
        check("ser", 16'(ser_pwr), {13'h0000, mdl[7][0], mdl[7][1], mdl[7][2]});
        check("target", 16'(black_cal.target), 16'(mdl[8][7:0]));
        check("exp", 16'(black_cal.samples_exp), 16'(mdl[8][10:8]));
        check("count", 16'(black_cal.sample_count), 16'(16'h0001 << mdl[8][10:8]));
        check("bias", 16'(serial_bias), mdl[0] & 16'h00ff);
        check("diode", 16'(temp_en), mdl[5] & 16'h0001);
    endtask

    task automatic wr(int k, logic [15:0] d);
        logic [15:0] q;
        frame(adr[k], 1'b1, d, 26, q);
        mdl[k] = (mdl[k] & ~msk[k]) | (d & msk[k]);
        outs();
    endtask

    task automatic rd(int k);
        logic [15:0] q;
        logic [15:0] e;
        e = (k == 6) ? (mdl[5][0] ? {8'h00, temp_code} : 16'h0000) : mdl[k];
        frame(adr[k], 1'b0, 16'h0000, 26, q);
        check("read", q, e);
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] q;
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        temp_code = 8'($random(seed));
        arst_n = 1'b0;
        mdl = rstv;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        outs();
        for (int k = 0; k < 11; k++) rd(k);
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 11; k++) begin
                wr(k, (r == 0) ? 16'hffff : 16'($random(seed)));
                rd(k);
            end
        end
        wr(5, 16'h0001);
        temp_code = 8'($random(seed));
        rd(6);
        wr(5, 16'h0000);
        rd(6);
        frame(adr[7], 1'b1, ~mdl[7], 12, q);
        outs();
        @(negedge sys_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        mdl = rstv;
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        outs();
        end_of_test();
    end

    // Watchdog, about twice the 23k cycles the frames take
    initial begin
        repeat (50000) @(posedge sys_clk);
        err_total++;
        end_of_test();
    end
endmodule

bind sensor_aux_config_regs sensor_aux_config_properties chk (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_spi_ss_n(i_spi_ss_n), .o_temp_diode_en(o_temp_diode_en),
    .o_pump(o_pump), .o_ser_pwr(o_ser_pwr), .o_black_cal(o_black_cal));
